// file: core/setup_memory_store_recall.sv
// setup memory store/recall command handler with its reply FIFO
// assumes rx bytes come from logic on pclk, tx bytes go to a serial sender
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps

// ----------------------------------------
// reply FIFO
// ----------------------------------------
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] arr [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW-1:0]    rd_nxt;
	logic [CW-1:0]    count_r;
	logic [CW-1:0]    count_nxt;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign count_nxt = CW'(count_r + CW'(push) - CW'(pop));
	assign rd_nxt    = pop ? AW'(rd_r + 1'b1) : rd_r;

	// head is registered so the output leaves a flip-flop; a push into the next head slot bypasses the array
	always_ff @(posedge clk)
	begin
		if (push)
			arr[wr_r] <= in_data;
		if (push && wr_r == rd_nxt)
			out_data <= in_data;
		else
			out_data <= arr[rd_nxt];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_r      <= '0;
			rd_r      <= '0;
			count_r   <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_r <= AW'(wr_r + 1'b1);
			if (pop)
				rd_r <= AW'(rd_r + 1'b1);
			count_r   <= count_nxt;
			in_ready  <= count_nxt != CW'(DEPTH);
			out_valid <= count_nxt != '0;
		end
	end
endmodule

// ----------------------------------------
// command handler
// ----------------------------------------
// Contract
// - store frame writes whole setup, name through reference level, into indexed slot
// - store and recall only touch slot memory, never running settings
// - recall takes two-digit index, reply echoes it then full slot contents
// - compat select 2: frequency field is ten digits in hertz
// - compat select 1: frequency field is seven characters in megahertz
// - setup name is 32 characters, always returned on recall
// - each field opens with its indicator letter, F for frequency
// - gain field is one digit, 0 manual, 1 automatic
// - acquisition range is three digits from listed codes, 001 allowed
// - tracking range is three digits from listed codes
// - MEM is recognised in both store and recall frames
// - tuner bandwidth is 007.5, 150.0 or 340.0
module setup_memory_store_recall
	import mem_store_pkg::*;
#(
	parameter int SLOTS      = 10,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	output logic [7:0]       tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready
);
	typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_BODY, ST_COMMIT, ST_REPLY} state_type;

	state_type   state_r;
	logic [1:0]  compat_format_select_r;
	logic [15:0] stores_r;
	logic [15:0] rejects_r;
	logic        query_r;
	logic        legacy_r;
	logic        bad_r;
	logic        bad_nxt;
	logic [2:0]  hcnt_r;
	logic [6:0]  pos_r;
	logic [6:0]  rcnt_r;
	logic [6:0]  slot_r;
	logic [7:0]  d_hi_r;
	logic [7:0]  d_lo_r;
	logic [39:0] sh_r;
	logic [39:0] sh_nxt;
	logic [7:0]  stage [REC_STD];
	logic [7:0]  mem [SLOTS*REC_STD];
	logic        take;
	logic [6:0]  rec_last;
	logic [6:0]  rep_last;
	logic        slot_ok;
	logic [6:0]  slot_val;
	int          np;
	logic [7:0]  exp_ch;
	logic [7:0]  reply_byte;
	logic        fifo_ready;
	logic        acc;

	function automatic logic is_digit(input logic [7:0] b);
		return b >= CH_0 && b <= CH_9;
	endfunction

	// legacy frames are three bytes shorter after the frequency field
	function automatic int norm_pos(input logic [6:0] p, input logic leg);
		return (leg && int'(p) >= POS_A - LEG_SHIFT) ? int'(p) + LEG_SHIFT : int'(p);
	endfunction

	assign take     = rx_valid && rx_ready;
	assign sh_nxt   = {sh_r[31:0], rx_data};
	assign rec_last = legacy_r ? 7'(REC_LEG - 1) : 7'(REC_STD - 1);
	assign rep_last = query_r ? 7'(REPLY_HDR + int'(rec_last)) : 7'(ACK_LEN - 1);
	assign slot_val = 7'(10 * int'(d_hi_r - CH_0) + int'(rx_data - CH_0));
	assign slot_ok  = is_digit(d_hi_r) && is_digit(rx_data) && int'(slot_val) < SLOTS;

	// ----------------------------------------
	// field checks
	// ----------------------------------------
	always_comb
	begin
		np      = norm_pos(pos_r, legacy_r);
		exp_ch  = ind_letter(np);
		bad_nxt = bad_r;
		if (exp_ch != 8'h00 && rx_data != exp_ch)
			bad_nxt = 1'b1;
		if (np == POS_GAIN && rx_data != CH_0 && rx_data != CH_1)
			bad_nxt = 1'b1;
		if (np == POS_ACQ_END && !range_ok(sh_nxt[23:0], 1'b1))
			bad_nxt = 1'b1;
		if (np == POS_TRK_END && !range_ok(sh_nxt[23:0], 1'b0))
			bad_nxt = 1'b1;
		if (np == POS_TBW_END && !tbw_ok(sh_nxt))
			bad_nxt = 1'b1;
	end

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r   <= ST_IDLE;
			rx_ready  <= 1'b1;
			query_r   <= 1'b0;
			legacy_r  <= 1'b0;
			bad_r     <= 1'b0;
			hcnt_r    <= 3'h0;
			pos_r     <= 7'h00;
			rcnt_r    <= 7'h00;
			slot_r    <= 7'h00;
			d_hi_r    <= 8'h00;
			d_lo_r    <= 8'h00;
			sh_r      <= 40'h0;
			stores_r  <= 16'h0000;
			rejects_r <= 16'h0000;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
					if (take && (rx_data == CH_SET || rx_data == CH_QRY))
					begin
						state_r  <= ST_HDR;
						query_r  <= rx_data == CH_QRY;
						legacy_r <= compat_format_select_r == COMPAT_LEGACY;
						hcnt_r   <= 3'h0;
						pos_r    <= 7'h00;
						bad_r    <= 1'b0;
					end
				ST_HDR:
					if (take)
					begin
						hcnt_r <= 3'(hcnt_r + 3'h1);
						if (hcnt_r == 3'h3)
							d_hi_r <= rx_data;
						if (((hcnt_r == 3'h0 || hcnt_r == 3'h2) && rx_data != CH_M) ||
							(hcnt_r == 3'h1 && rx_data != CH_E))
							state_r <= ST_IDLE;
						else if (hcnt_r == 3'(HDR_LAST))
						begin
							d_lo_r <= rx_data;
							slot_r <= slot_val;
							if (!slot_ok)
							begin
								state_r   <= ST_IDLE;
								rejects_r <= 16'(rejects_r + 16'h0001);
							end
							else if (query_r)
							begin
								state_r  <= ST_REPLY;
								rx_ready <= 1'b0;
								rcnt_r   <= 7'h00;
							end
							else
								state_r <= ST_BODY;
						end
					end
				ST_BODY:
					if (take)
					begin
						sh_r  <= sh_nxt;
						bad_r <= bad_nxt;
						pos_r <= 7'(pos_r + 7'h01);
						if (pos_r == rec_last)
						begin
							pos_r <= 7'h00;
							if (bad_nxt)
							begin
								state_r   <= ST_IDLE;
								rejects_r <= 16'(rejects_r + 16'h0001);
							end
							else
							begin
								state_r  <= ST_COMMIT;
								rx_ready <= 1'b0;
							end
						end
					end
				ST_COMMIT:
				begin
					pos_r <= 7'(pos_r + 7'h01);
					if (pos_r == rec_last)
					begin
						state_r  <= ST_REPLY;
						rcnt_r   <= 7'h00;
						stores_r <= 16'(stores_r + 16'h0001);
					end
				end
				ST_REPLY:
					if (fifo_ready)
					begin
						rcnt_r <= 7'(rcnt_r + 7'h01);
						if (rcnt_r == rep_last)
						begin
							state_r  <= ST_IDLE;
							rx_ready <= 1'b1;
						end
					end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// staging and slot memory
	// ----------------------------------------
	// the frame is staged whole so a rejected store never reaches the slot
	always_ff @(posedge pclk)
	begin
		if (state_r == ST_BODY && take)
			stage[pos_r] <= rx_data;
	end

	always_ff @(posedge pclk)
	begin
		if (state_r == ST_COMMIT)
			mem[int'(slot_r) * REC_STD + int'(pos_r)] <= stage[pos_r];
	end

	always_comb
	begin
		if (rcnt_r == 7'h00)
			reply_byte = query_r ? CH_QRY : CH_SET;
		else if (rcnt_r == 7'h01 || rcnt_r == 7'h03)
			reply_byte = CH_M;
		else if (rcnt_r == 7'h02)
			reply_byte = CH_E;
		else if (rcnt_r == 7'h04)
			reply_byte = d_hi_r;
		else if (rcnt_r == 7'h05)
			reply_byte = d_lo_r;
		else
			reply_byte = mem[int'(slot_r) * REC_STD + int'(rcnt_r) - REPLY_HDR];
	end

	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_reply_fifo (
		.clk       (pclk),
		.rst_n     (presetn),
		.in_data   (reply_byte),
		.in_valid  (state_r == ST_REPLY),
		.in_ready  (fifo_ready),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	assign acc = psel && penable;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready                 <= 1'b0;
			prdata                 <= 32'h0000_0000;
			pslverr                <= 1'b0;
			compat_format_select_r <= COMPAT_RST;
		end
		else
		begin
			pready <= acc && !pready;
			if (acc && !pready)
			begin
				pslverr <= paddr != ADDR_CTRL && paddr != ADDR_STAT;
				if (paddr == ADDR_CTRL)
					prdata <= {23'h0, state_r != ST_IDLE, 6'h00, compat_format_select_r};
				else if (paddr == ADDR_STAT)
					prdata <= {rejects_r, stores_r};
				else
					prdata <= 32'h0000_0000;
			end
			if (acc && pready && pwrite && paddr == ADDR_CTRL)
				compat_format_select_r <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_mem_hdr;
		@(posedge pclk) disable iff (!presetn)
		state_r == ST_HDR && take && hcnt_r == 3'h1 && rx_data != CH_E |=> state_r == ST_IDLE;
	endproperty
	a_mem_hdr: assert property (p_mem_hdr) else $error("bad command code accepted");

	property p_query_no_store;
		@(posedge pclk) disable iff (!presetn)
		state_r == ST_HDR && query_r |=> state_r != ST_COMMIT && state_r != ST_BODY;
	endproperty
	a_query_no_store: assert property (p_query_no_store) else $error("recall wrote memory");

	property p_commit_len;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_r == ST_COMMIT) |-> (state_r == ST_COMMIT)[*8] ##0 (stores_r == $past(stores_r, 8));
	endproperty
	a_commit_len: assert property (p_commit_len) else $error("commit cut short");

	property p_echo;
		@(posedge pclk) disable iff (!presetn)
		state_r == ST_HDR && take && query_r && hcnt_r == 3'(HDR_LAST) && slot_ok |=>
			state_r == ST_REPLY && rcnt_r == 7'h00 && d_lo_r == $past(rx_data) && reply_byte == CH_QRY;
	endproperty
	a_echo: assert property (p_echo) else $error("index not echoed");

	property p_len_std;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_r == ST_COMMIT) && !legacy_r |-> $past(pos_r) == 7'(REC_STD - 1);
	endproperty
	a_len_std: assert property (p_len_std) else $error("standard frame length wrong");

	property p_len_leg;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_r == ST_COMMIT) && legacy_r |-> $past(pos_r) == 7'(REC_LEG - 1);
	endproperty
	a_len_leg: assert property (p_len_leg) else $error("legacy frame length wrong");

	property p_freq_ind;
		@(posedge pclk) disable iff (!presetn)
		state_r == ST_BODY && take && np == POS_F && rx_data != CH_F && pos_r != rec_last |=> bad_r;
	endproperty
	a_freq_ind: assert property (p_freq_ind) else $error("missing F accepted");

	property p_gain;
		@(posedge pclk) disable iff (!presetn)
		state_r == ST_BODY && take && np == POS_GAIN && rx_data > CH_1 |=> bad_r;
	endproperty
	a_gain: assert property (p_gain) else $error("bad gain digit accepted");

	property p_reject;
		@(posedge pclk) disable iff (!presetn)
		state_r == ST_BODY && take && pos_r == rec_last && bad_nxt |=>
			state_r == ST_IDLE && rejects_r == 16'($past(rejects_r) + 16'h0001);
	endproperty
	a_reject: assert property (p_reject) else $error("bad store not rejected");

	c_store: cover property (@(posedge pclk) disable iff (!presetn) $fell(state_r == ST_COMMIT));
	c_query: cover property (@(posedge pclk) disable iff (!presetn) state_r == ST_REPLY && query_r);
	c_reject: cover property (@(posedge pclk) disable iff (!presetn) $changed(rejects_r));
endmodule

// file: core/mem_store_pkg.sv
// constants for the setup memory store/recall command handler
// assumes a byte stream from a serial front end and an APB register bus
package mem_store_pkg;
	// ----------------------------------------
	// frame layout, positions after the slot index
	// ----------------------------------------
	localparam int NAME_LEN  = 32;
	localparam int FREQ_STD  = 10;
	localparam int FREQ_LEG  = 7;
	localparam int LEG_SHIFT = FREQ_STD - FREQ_LEG;
	localparam int REC_STD   = 114;
	localparam int REC_LEG   = REC_STD - LEG_SHIFT;
	localparam int HDR_LAST  = 4;
	localparam int REPLY_HDR = 6;
	localparam int ACK_LEN   = 4;
	localparam int POS_N0 = 0;
	localparam int POS_F  = 33;
	localparam int POS_A  = 44;
	localparam int POS_Q  = 46;
	localparam int POS_T  = 50;
	localparam int POS_U  = 54;
	localparam int POS_V  = 60;
	localparam int POS_M  = 65;
	localparam int POS_R  = 71;
	localparam int POS_X  = 77;
	localparam int POS_S  = 83;
	localparam int POS_H  = 89;
	localparam int POS_P  = 94;
	localparam int POS_N2 = 100;
	localparam int POS_G  = 106;
	localparam int POS_D  = 112;
	localparam int POS_GAIN    = POS_A + 1;
	localparam int POS_ACQ_END = POS_Q + 3;
	localparam int POS_TRK_END = POS_T + 3;
	localparam int POS_TBW_END = POS_U + 5;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	localparam logic [11:0] ADDR_CTRL     = 12'h000;
	localparam logic [11:0] ADDR_STAT     = 12'h004;
	localparam logic [1:0]  COMPAT_RST    = 2'h2;
	localparam logic [1:0]  COMPAT_LEGACY = 2'h1;
	localparam int          CTRL_BUSY_BIT = 8;
	// ----------------------------------------
	// characters
	// ----------------------------------------
	localparam logic [7:0] CH_SET = 8'h24;
	localparam logic [7:0] CH_QRY = 8'h3F;
	localparam logic [7:0] CH_M   = 8'h4D;
	localparam logic [7:0] CH_E   = 8'h45;
	localparam logic [7:0] CH_F   = 8'h46;
	localparam logic [7:0] CH_0   = 8'h30;
	localparam logic [7:0] CH_1   = 8'h31;
	localparam logic [7:0] CH_9   = 8'h39;

	function automatic logic [7:0] ind_letter(input int p);
		case (p)
			POS_N0, POS_N2: return 8'h4E;
			POS_F: return CH_F;
			POS_A: return 8'h41;
			POS_Q: return 8'h51;
			POS_T: return 8'h54;
			POS_U: return 8'h55;
			POS_V: return 8'h56;
			POS_M: return CH_M;
			POS_R: return 8'h52;
			POS_X: return 8'h58;
			POS_S: return 8'h53;
			POS_H: return 8'h48;
			POS_P: return 8'h50;
			POS_G: return 8'h47;
			POS_D: return 8'h44;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic range_ok(input logic [23:0] c, input logic allow_tbw);
		return (allow_tbw && c == 24'h303031) || c == 24'h303130 || c == 24'h303230 || c == 24'h303530 ||
			c == 24'h313030 || c == 24'h323030 || c == 24'h353030 || c == 24'h373030;
	endfunction

	function automatic logic tbw_ok(input logic [39:0] c);
		return c == 40'h3030372E35 || c == 40'h3135302E30 || c == 40'h3334302E30;
	endfunction
endpackage

// file: tb/host_model.sv
// remote control computer model: builds and sends store and recall frames, collects reply bytes
// assumes the handler takes a byte at a rising edge where rx_valid and rx_ready are both high
`timescale 1ns/1ps

module host_model (
	input  wire logic       pclk,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] body[$];
	logic [7:0] got[$];
	logic       hold;
	logic       slow;
	logic       hung;

	initial
	begin
		rx_data  = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		hold     = 1'b0;
		slow     = 1'b0;
		hung     = 1'b0;
	end

	// ----------------------------------------
	// reply collector
	// ----------------------------------------
	// slow mode takes a byte only every other cycle, hold refuses all so the reply FIFO fills
	always @(posedge pclk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= hold ? 1'b0 : (slow ? ~tx_ready : 1'b1);
	end

	// ----------------------------------------
	// frame building and sending
	// ----------------------------------------
	task automatic build(input logic [15:0] idx, input logic leg, input logic [7:0] gain,
		input logic [23:0] acq, input logic [23:0] tracking_range, input logic [39:0] tuner_bandwidth);
		int           pos[16] = '{0, 33, 44, 46, 50, 54, 60, 65, 71, 77, 83, 89, 94, 100, 106, 112};
		logic [127:0] ltr     = "NFAQTUVMRXSHPNGD";
		body.delete();
		for (int i = 0; i < 114; i++)
			body.push_back(8'h30 + 8'(i % 10));
		for (int k = 0; k < 16; k++)
			body[pos[k]] = ltr[127-8*k -: 8];
		body[45] = gain;
		for (int k = 0; k < 3; k++)
		begin
			body[47+k] = acq[23-8*k -: 8];
			body[51+k] = tracking_range[23-8*k -: 8];
		end
		for (int k = 0; k < 5; k++)
			body[55+k] = tuner_bandwidth[39-8*k -: 8];
		if (leg)
			for (int k = 0; k < 3; k++)
				body.delete(41); // legacy frequency keeps seven of the ten characters
	endtask

	// the byte is held until an edge sees rx_ready; afterwards the line shows the inverse, not a stale byte
	task automatic send(input logic [7:0] q[$]);
		int n;
		foreach (q[i])
		begin
			rx_data  <= q[i];
			rx_valid <= 1'b1;
			n = 0;
			do
			begin
				@(posedge pclk);
				n++;
			end while (rx_ready !== 1'b1 && n < 3000);
			if (n >= 3000)
				hung = 1'b1;
		end
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data;
	endtask

	task automatic store(input logic [15:0] idx, input logic leg, input logic [7:0] gain,
		input logic [23:0] acq, input logic [23:0] tracking_range, input logic [39:0] tuner_bandwidth);
		build(idx, leg, gain, acq, tracking_range, tuner_bandwidth);
		send({8'h24, 8'h4D, 8'h45, 8'h4D, idx[15:8], idx[7:0], body});
	endtask

	task automatic query(input logic [15:0] idx);
		send({8'h3F, 8'h4D, 8'h45, 8'h4D, idx[15:8], idx[7:0]});
	endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the setup memory store/recall handler
// assumes the host model in host_model.sv and APB register access to the handler
`timescale 1ns/1ps

module tb;
	import mem_store_pkg::*;
	typedef struct packed {
		logic [15:0] idx;
		logic        leg;
		logic [7:0]  gain;
		logic [23:0] acq;
		logic [23:0] tracking_range;
		logic [39:0] tuner_bandwidth;
		logic        ok;
	} row_type;

	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        rx_ready;
	logic [7:0]  tx_data;
	logic        tx_valid;
	logic        tx_ready;
	logic [31:0] r;
	logic        e;
	logic [7:0]  keep[$];
	int          mismatches;
	int          check_count;
	int          acc;
	int          rej;
	row_type     rows[13] = '{
		'{16'h3030, 1'b0, "0", "001", "010", "007.5", 1'b1},
		'{16'h3031, 1'b0, "1", "010", "020", "150.0", 1'b1},
		'{16'h3032, 1'b1, "0", "020", "050", "340.0", 1'b1},
		'{16'h3033, 1'b0, "1", "050", "100", "007.5", 1'b1},
		'{16'h3034, 1'b0, "0", "100", "200", "150.0", 1'b1},
		'{16'h3035, 1'b0, "1", "200", "500", "340.0", 1'b1},
		'{16'h3036, 1'b1, "1", "500", "700", "007.5", 1'b1},
		'{16'h3039, 1'b0, "0", "700", "010", "150.0", 1'b1},
		'{16'h3130, 1'b0, "1", "010", "010", "150.0", 1'b0},
		'{16'h3031, 1'b0, "1", "000", "010", "150.0", 1'b0},
		'{16'h3031, 1'b0, "1", "010", "001", "150.0", 1'b0},
		'{16'h3030, 1'b0, "2", "010", "010", "150.0", 1'b0},
		'{16'h3031, 1'b0, "1", "010", "010", "150.5", 1'b0}};

	setup_memory_store_recall setup_memory_store_recall_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));

	host_model host_model_i (.pclk(pclk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// whole-run limit, so a stuck handshake still reaches the verdict
	initial
	begin
		repeat (90000) @(posedge pclk);
		mismatches++;
		summarize();
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic summarize();
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 50)
		begin
			mismatches++;
			summarize();
		end
	endtask

	// idle means handler not busy and n reply bytes collected
	task automatic wait_idle(input int n);
		int t;
		t = 0;
		do
		begin
			apb(1'b0, ADDR_CTRL, 32'h0);
			t++;
		end while ((r[CTRL_BUSY_BIT] !== 1'b0 || host_model_i.got.size() < n) && t < 400);
		if (t >= 400 || host_model_i.hung)
		begin
			mismatches++;
			summarize();
		end
	endtask

	task automatic expect_reply(input logic [7:0] hd, input logic [15:0] idx, input logic [7:0] b[$]);
		logic [7:0] x[$];
		x = {hd, 8'h4D, 8'h45, 8'h4D};
		if (hd == 8'h3F)
			x = {x, idx[15:8], idx[7:0], b};
		chk("reply_len", 32'(host_model_i.got.size()), 32'(x.size()));
		foreach (x[i])
			chk("reply_byte", {24'h0, host_model_i.got[i]}, {24'h0, x[i]});
		host_model_i.got.delete();
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_reset", r, 32'h00000002);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("stat_reset", r, 32'h00000000);
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped_err", {31'h0, e}, 32'h00000001);
		chk("unmapped_data", r, 32'h00000000);
		foreach (rows[i])
		begin
			host_model_i.slow <= i[0];
			apb(1'b1, ADDR_CTRL, rows[i].leg ? 32'h1 : 32'h2);
			host_model_i.store(rows[i].idx, rows[i].leg, rows[i].gain, rows[i].acq, rows[i].tracking_range, rows[i].tuner_bandwidth);
			wait_idle(rows[i].ok ? 4 : 0);
			if (rows[i].ok)
			begin
				acc++;
				expect_reply(8'h24, rows[i].idx, host_model_i.body);
			end
			else
			begin
				rej++;
				chk("reject_silent", 32'(host_model_i.got.size()), 32'h0);
			end
			apb(1'b0, ADDR_STAT, 32'h0);
			chk("stat_count", r, {16'(rej), 16'(acc)});
			if (rows[i].ok)
			begin
				host_model_i.query(rows[i].idx);
				wait_idle(rows[i].leg ? 117 : 120);
				expect_reply(8'h3F, rows[i].idx, host_model_i.body);
			end
			if (i == 0)
				keep = host_model_i.body;
		end
		// a misspelt command letter must be dropped without reply or count
		host_model_i.send({8'h3F, 8'h4D, 8'h58, 8'h4D, 8'h30, 8'h33});
		wait_idle(0);
		chk("bad_letter_silent", 32'(host_model_i.got.size()), 32'h0);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("bad_letter_stat", r, {16'(rej), 16'(acc)});
		// slot 0 saw a rejected store; recall it with the reply FIFO held full first
		apb(1'b1, ADDR_CTRL, 32'h2);
		host_model_i.hold <= 1'b1;
		host_model_i.query(16'h3030);
		repeat (100) @(posedge pclk);
		chk("full_rx_ready", {31'h0, rx_ready}, 32'h0);
		chk("full_tx_valid", {31'h0, tx_valid}, 32'h1);
		host_model_i.hold <= 1'b0;
		wait_idle(120);
		expect_reply(8'h3F, 16'h3030, keep);
		// a reset in mid-run restores the standard format and clears the counters, slots survive
		apb(1'b1, ADDR_CTRL, 32'h1);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_rerst", r, 32'h00000002);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("stat_rerst", r, 32'h00000000);
		host_model_i.query(16'h3030);
		wait_idle(120);
		expect_reply(8'h3F, 16'h3030, keep);
		summarize();
	end
endmodule
